// ==== common/dcr_cfg.svh ====
`ifndef DCR_CFG_SVH
`define DCR_CFG_SVH

// Register offsets
`define DCR_ADDR_W 8
`define DCR_OFF_DEV_ID 8'h00
`define DCR_OFF_PROG_MEM_IDENT 8'h01
`define DCR_OFF_C0_CTL_A 8'h02
`define DCR_OFF_C0_CTL_B 8'h03
`define DCR_OFF_C1_CTL_A 8'h04

// Field positions
`define DCR_PART_ID_LSB 3
`define DCR_PART_ID_MSB 5
`define DCR_MEM_ID_LSB 2
`define DCR_MEM_ID_MSB 7
`define DCR_MEM_REV_LSB 0
`define DCR_MEM_REV_MSB 1
`define DCR_FPWM_BIT 4
`define DCR_DIS_BIT 3
`define DCR_SRC_LSB 1
`define DCR_SRC_MSB 2
`define DCR_EN_BIT 0
`define DCR_ILIM_LSB 3
`define DCR_ILIM_MSB 5
`define DCR_SLEW_LSB 0
`define DCR_SLEW_MSB 2

// Reset values
`define DCR_RST_CTL_A 8'h08
`define DCR_RST_CTL_B 8'h1A
`define DCR_RST_MEM_REV 2'h0

// Writable masks; reserved bits stay zero
`define DCR_MASK_CTL_A 8'h1F
`define DCR_MASK_CTL_B 8'h3F

`endif

// ==== common/dcr_pkg.sv ====
package dcr_pkg;
   typedef enum logic [1:0]
   {
      DCR_ST_RESET = 2'b00,
      DCR_ST_LOAD = 2'b01,
      DCR_ST_RUN = 2'b10
   } dcr_state_t;

   typedef enum logic [1:0]
   {
      DCR_SRC_BIT_ONLY = 2'b00,
      DCR_SRC_PIN_ONE = 2'b01,
      DCR_SRC_PIN_TWO = 2'b10,
      DCR_SRC_PIN_THREE = 2'b11
   } dcr_src_t;

   typedef struct packed
   {
      dcr_state_t state;
      logic [2:0] part_id;
      logic [5:0] mem_id;
      logic [1:0] mem_rev;
      logic [7:0] c0_ctl_a;
      logic [7:0] c0_ctl_b;
      logic [7:0] c1_ctl_a;
      logic [7:0] rd_data;
      logic [2:0] pin_s1;
      logic [2:0] pin_s2;
      logic [2:0] pin_s3;
      logic [2:0] pin_q;
      logic c0_on;
      logic c1_on;
      logic c0_dis;
      logic c1_dis;
      logic ready;
   } dcr_state_s_t;
endpackage

// ==== design/dcr_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "dcr_cfg.svh"

// Summary of operation
// - Part id bits 5-3 from memory.
// - Memory id in bits 7-2.
// - Memory revision bits 1-0, reset zero.
// - Marked defaults load from programmable memory.
// - Converter 0 bit 4 forces PWM.
// - Converter 0 bit 3 discharge, reset one.
// - Converter 0 source ANDs selected pin.
// - Converter 0 bit 0 enables it.
// - Converter 0 current limit code 5-3.
// - Converter 0 slew code bits 2-0.
// - Converter 1 bit 4 forces PWM.
// - Converter 1 bit 3 discharge while disabled.
// - Converter 1 source ANDs selected pin.
// - Converter 1 bit 0 enables it.
module dcr_regs
   import dcr_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   input wire logic clk_en_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   input wire logic mem_valid_i,
   input wire logic [2:0] mem_part_id_i,
   input wire logic [5:0] mem_id_i,
   input wire logic [1:0] mem_rev_i,
   input wire logic [7:0] mem_c0_ctl_a_i,
   input wire logic [7:0] mem_c0_ctl_b_i,
   input wire logic [7:0] mem_c1_ctl_a_i,
   input wire logic [2:0] enable_pin_i,
   output logic conv0_on_o,
   output logic conv0_force_pwm_o,
   output logic conv0_discharge_o,
   output logic [2:0] conv0_current_limit_o,
   output logic [2:0] conv0_slew_code_o,
   output logic conv1_on_o,
   output logic conv1_force_pwm_o,
   output logic conv1_discharge_o,
   output logic ready_o
);

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic qualify(input logic [7:0] ctl, input logic [2:0] pins);
      logic r;
      r = ctl[`DCR_EN_BIT];
      case (dcr_src_t'(ctl[`DCR_SRC_MSB:`DCR_SRC_LSB]))
         DCR_SRC_PIN_ONE: r = r & pins[0];
         DCR_SRC_PIN_TWO: r = r & pins[1];
         DCR_SRC_PIN_THREE: r = r & pins[2];
         default: r = ctl[`DCR_EN_BIT];
      endcase
      return r;
   endfunction

   // Memory-default fields take loaded value, discharge bit keeps fixed one
   function automatic logic [7:0] load_a(input logic [7:0] mem);
      logic [7:0] v;
      v = mem & `DCR_MASK_CTL_A;
      v[`DCR_DIS_BIT] = 1'b1;
      return v;
   endfunction

   dcr_state_s_t st;
   dcr_state_s_t next_st;
   logic [2:0] pin_stable;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb
   begin
      next_st = st;
      pin_stable = st.pin_q;
      next_st.pin_s1 = enable_pin_i;
      next_st.pin_s2 = st.pin_s1;
      next_st.pin_s3 = st.pin_s2;
      // Pin change counts only when second and third stages agree
      for (int i = 0; i < 3; i++)
      begin
         if (st.pin_s2[i] == st.pin_s3[i])
         begin
            pin_stable[i] = st.pin_s3[i];
         end
      end
      next_st.pin_q = pin_stable;
      case (st.state)
         DCR_ST_RESET:
         begin
            next_st.state = DCR_ST_LOAD;
         end
         DCR_ST_LOAD:
         begin
            // Converters held off until memory defaults arrive
            if (mem_valid_i)
            begin
               next_st.part_id = mem_part_id_i;
               next_st.mem_id = mem_id_i;
               next_st.mem_rev = mem_rev_i;
               next_st.c0_ctl_a = load_a(mem_c0_ctl_a_i);
               next_st.c0_ctl_b = mem_c0_ctl_b_i & `DCR_MASK_CTL_B;
               next_st.c1_ctl_a = load_a(mem_c1_ctl_a_i);
               next_st.state = DCR_ST_RUN;
            end
         end
         DCR_ST_RUN:
         begin
            if (wr_i)
            begin
               // Identity offsets not decoded for write
               case (addr_i)
                  `DCR_OFF_C0_CTL_A: next_st.c0_ctl_a = wdata_i & `DCR_MASK_CTL_A;
                  `DCR_OFF_C0_CTL_B: next_st.c0_ctl_b = wdata_i & `DCR_MASK_CTL_B;
                  `DCR_OFF_C1_CTL_A: next_st.c1_ctl_a = wdata_i & `DCR_MASK_CTL_A;
                  default: next_st.c1_ctl_a = st.c1_ctl_a;
               endcase
            end
         end
         default:
         begin
            next_st.state = DCR_ST_RESET;
         end
      endcase
      next_st.rd_data = 8'h00;
      if (rd_i)
      begin
         case (addr_i)
            `DCR_OFF_DEV_ID: next_st.rd_data = {2'h0, st.part_id, 3'h0};
            `DCR_OFF_PROG_MEM_IDENT: next_st.rd_data = {st.mem_id, st.mem_rev};
            `DCR_OFF_C0_CTL_A: next_st.rd_data = st.c0_ctl_a;
            `DCR_OFF_C0_CTL_B: next_st.rd_data = st.c0_ctl_b;
            `DCR_OFF_C1_CTL_A: next_st.rd_data = st.c1_ctl_a;
            default: next_st.rd_data = 8'h00;
         endcase
      end
      next_st.ready = (st.state == DCR_ST_RUN);
      next_st.c0_on = (st.state == DCR_ST_RUN) && qualify(st.c0_ctl_a, st.pin_q);
      next_st.c1_on = (st.state == DCR_ST_RUN) && qualify(st.c1_ctl_a, st.pin_q);
      next_st.c0_dis = st.c0_ctl_a[`DCR_DIS_BIT] & ~next_st.c0_on;
      next_st.c1_dis = st.c1_ctl_a[`DCR_DIS_BIT] & ~next_st.c1_on;
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge ref_clk_i)
   begin
      if (!reset_n_i)
      begin
         st <= '0;
         st.state <= DCR_ST_RESET;
         st.mem_rev <= `DCR_RST_MEM_REV;
         st.c0_ctl_a <= `DCR_RST_CTL_A;
         st.c0_ctl_b <= `DCR_RST_CTL_B;
         st.c1_ctl_a <= `DCR_RST_CTL_A;
      end
      else if (clk_en_i)
      begin
         st <= next_st;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign rdata_o = st.rd_data;
   assign conv0_on_o = st.c0_on;
   assign conv0_force_pwm_o = st.c0_ctl_a[`DCR_FPWM_BIT];
   assign conv0_discharge_o = st.c0_dis;
   assign conv0_current_limit_o = st.c0_ctl_b[`DCR_ILIM_MSB:`DCR_ILIM_LSB];
   assign conv0_slew_code_o = st.c0_ctl_b[`DCR_SLEW_MSB:`DCR_SLEW_LSB];
   assign conv1_on_o = st.c1_on;
   assign conv1_force_pwm_o = st.c1_ctl_a[`DCR_FPWM_BIT];
   assign conv1_discharge_o = st.c1_dis;
   assign ready_o = st.ready;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   sequence s_wr_a0;
      wr_i && clk_en_i && st.state == DCR_ST_RUN && addr_i == `DCR_OFF_C0_CTL_A;
   endsequence

   a_id_write_none: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      (st.state == DCR_ST_RUN && clk_en_i) |=> $stable(st.part_id) && $stable(st.mem_id))
      else $error("identity changed after load");
   a_rsv_zero: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      st.c0_ctl_a[7:5] == 3'h0 && st.c0_ctl_b[7:6] == 2'h0 && st.c1_ctl_a[7:5] == 3'h0)
      else $error("reserved bit set");
   a_dev_read: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      (rd_i && clk_en_i && addr_i == `DCR_OFF_DEV_ID) |=> rdata_o == {2'h0, $past(st.part_id), 3'h0})
      else $error("identity read wrong");
   a_otp_read: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      (rd_i && clk_en_i && addr_i == `DCR_OFF_PROG_MEM_IDENT) |=> rdata_o == {$past(st.mem_id), $past(st.mem_rev)})
      else $error("memory id read wrong");
   a_c0_write: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      s_wr_a0 |=> conv0_force_pwm_o == $past(wdata_i[4]) ##1 (!clk_en_i || conv0_on_o == $past(st.c0_ctl_a[0] && (st.c0_ctl_a[2:1] == 2'h0 || st.pin_q[st.c0_ctl_a[2:1] - 2'h1]))))
      else $error("converter 0 write not applied");
   a_c0_pin_gate: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      (clk_en_i && st.c0_ctl_a[2:1] == 2'h2 && !st.pin_q[1]) |=> !conv0_on_o)
      else $error("converter 0 on without pin");
   a_c1_pin_gate: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      (clk_en_i && st.c1_ctl_a[2:1] == 2'h3 && !st.pin_q[2]) |=> !conv1_on_o)
      else $error("converter 1 on without pin");
   a_c0_disch: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      conv0_discharge_o |-> !conv0_on_o)
      else $error("discharge while on");
   a_c1_disch: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      (clk_en_i && st.state == DCR_ST_RUN && !conv1_on_o && st.c1_ctl_a[3] && $stable(st.c1_ctl_a))
      |=> conv1_discharge_o || conv1_on_o)
      else $error("converter 1 discharge missing");
   a_load_run: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      (clk_en_i && st.state == DCR_ST_LOAD && mem_valid_i) |=> ready_o == 1'b0 ##0 st.state == DCR_ST_RUN
      ##0 st.c0_ctl_b == ($past(mem_c0_ctl_b_i) & `DCR_MASK_CTL_B))
      else $error("memory defaults not loaded");

endmodule
`default_nettype wire

// ==== verification/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "dcr_cfg.svh"
module testbench;
   import dcr_pkg::*;
   logic ref_clk_i = 1'b0, reset_n_i = 1'b0, clk_en_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
   logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o, mem_c0_ctl_a_i, mem_c0_ctl_b_i;
   logic [7:0] mem_c1_ctl_a_i;
   logic mem_valid_i = 1'b0, ready_o, c0_on, c0_pwm, c0_dis, c1_on, c1_pwm, c1_dis;
   logic [2:0] mem_part_id_i, enable_pin_i = 3'h0, c0_lim, c0_slew;
   logic [5:0] mem_id_i;
   logic [1:0] mem_rev_i;
   logic [7:0] exp_q[$];
   logic rd_seen = 1'b0;
   integer failures = 0, check_count = 0, seed = 49142, i, c, v, p;
   dcr_regs i_dut (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .mem_valid_i(mem_valid_i), .mem_part_id_i(mem_part_id_i), .mem_id_i(mem_id_i),
      .mem_rev_i(mem_rev_i), .mem_c0_ctl_a_i(mem_c0_ctl_a_i), .mem_c0_ctl_b_i(mem_c0_ctl_b_i),
      .mem_c1_ctl_a_i(mem_c1_ctl_a_i), .enable_pin_i(enable_pin_i), .conv0_on_o(c0_on),
      .conv0_force_pwm_o(c0_pwm), .conv0_discharge_o(c0_dis), .conv0_current_limit_o(c0_lim),
      .conv0_slew_code_o(c0_slew), .conv1_on_o(c1_on), .conv1_force_pwm_o(c1_pwm),
      .conv1_discharge_o(c1_dis), .ready_o(ready_o));
   always #5 ref_clk_i = ~ref_clk_i;
   // ----------------------------------------
   // Bus tasks and comparisons
   // ----------------------------------------
   task automatic compare_read(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp)
      begin
         failures++;
         $display("[ERR] %0t read data %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic compare_out(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp)
      begin
         failures++;
         $display("[ERR] %0t converter outputs %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge ref_clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic read_reg(input logic [7:0] a, input logic [7:0] exp);
      @(posedge ref_clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      exp_q.push_back(exp);
      @(posedge ref_clk_i);
      rd_i <= 1'b0;
   endtask
   task automatic tally_and_finish;
      $display("Comparisons %0d, mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic wait_ready;
      for (i = 0; i < 50 && ready_o !== 1'b1; i++)
         @(posedge ref_clk_i);
      if (ready_o !== 1'b1)
      begin
         failures++;
         $display("[ERR] %0t defaults never loaded", $time);
         tally_and_finish();
      end
   endtask
   // Read data stand only in the cycle after the strobe
   always @(posedge ref_clk_i)
   begin
      if (rd_seen && exp_q.size() > 0)
         compare_read(rdata_o, exp_q.pop_front());
      rd_seen <= rd_i;
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      mem_part_id_i = $random(seed);
      mem_id_i = $random(seed);
      mem_rev_i = $random(seed);
      mem_c0_ctl_a_i = $random(seed) & 8'h1F;
      mem_c0_ctl_b_i = $random(seed) & 8'h3F;
      mem_c1_ctl_a_i = $random(seed) & 8'h17;
      repeat (16) @(posedge ref_clk_i);
      reset_n_i <= 1'b1;
      write_reg(`DCR_OFF_C0_CTL_A, 8'h17);
      mem_valid_i <= 1'b1;
      wait_ready();
      read_reg(`DCR_OFF_DEV_ID, {2'b00, mem_part_id_i, 3'b000});
      read_reg(`DCR_OFF_PROG_MEM_IDENT, {mem_id_i, mem_rev_i});
      read_reg(`DCR_OFF_C0_CTL_A, mem_c0_ctl_a_i | 8'h08);
      read_reg(`DCR_OFF_C0_CTL_B, mem_c0_ctl_b_i);
      read_reg(`DCR_OFF_C1_CTL_A, mem_c1_ctl_a_i | 8'h08);
      // Identity and unmapped places refuse writes
      write_reg(`DCR_OFF_DEV_ID, 8'hFF);
      write_reg(`DCR_OFF_PROG_MEM_IDENT, 8'h00);
      write_reg(8'h05, 8'hFF);
      read_reg(`DCR_OFF_DEV_ID, {2'b00, mem_part_id_i, 3'b000});
      read_reg(`DCR_OFF_PROG_MEM_IDENT, {mem_id_i, mem_rev_i});
      read_reg(8'h05, 8'h00);
      write_reg(`DCR_OFF_C0_CTL_A, 8'hE8);
      read_reg(`DCR_OFF_C0_CTL_A, 8'h08);
      write_reg(`DCR_OFF_C1_CTL_A, 8'hFF);
      read_reg(`DCR_OFF_C1_CTL_A, 8'h1F);
      // Every source code against every pin pattern
      for (c = 0; c < 2; c++)
         for (v = 0; v < 32; v++)
            for (p = 0; p < 8; p++)
            begin
               logic [3:0] pins;
               logic on;
               pins = {p[2:0], 1'b1};
               on = v[0] & pins[v[2:1]];
               // Pins change on the clock edge, not mid-cycle
               @(posedge ref_clk_i);
               enable_pin_i <= p[2:0];
               write_reg(c ? `DCR_OFF_C1_CTL_A : `DCR_OFF_C0_CTL_A, v[7:0]);
               repeat (8) @(posedge ref_clk_i);
               #1;
               if (c == 0)
                  compare_out({5'h00, c0_on, c0_pwm, c0_dis}, {5'h00, on, v[4], v[3] & ~on});
               else
                  compare_out({5'h00, c1_on, c1_pwm, c1_dis}, {5'h00, on, v[4], v[3] & ~on});
            end
      // Limit and slew codes rewritten during operation
      for (v = 0; v < 12; v++)
      begin
         p = $random(seed);
         write_reg(`DCR_OFF_C0_CTL_B, p[7:0]);
         read_reg(`DCR_OFF_C0_CTL_B, p[7:0] & 8'h3F);
         #1;
         compare_out({2'b00, c0_lim, c0_slew}, {2'b00, p[5:3], p[2:0]});
      end
      // Second reset mid-run restores the documented values
      @(posedge ref_clk_i);
      reset_n_i <= 1'b0;
      repeat (3) @(posedge ref_clk_i);
      #1;
      compare_out({c0_lim, c0_slew, c0_pwm, c1_pwm}, {3'h3, 3'h2, 2'b00});
      compare_out({4'h0, ready_o, c0_on, c1_on, c0_dis}, 8'h00);
      @(posedge ref_clk_i);
      reset_n_i <= 1'b1;
      wait_ready();
      read_reg(`DCR_OFF_C0_CTL_B, mem_c0_ctl_b_i);
      repeat (3) @(posedge ref_clk_i);
      tally_and_finish();
   end
endmodule
`default_nettype wire
